// ==== hw/usbirq_core.sv ====
// USB interrupt flags, enable masks and received frame number
`timescale 1ns/10ps
`include "usbirq_params.svh"
module usbirq_core
	import usbirq_pkg::*;
(
	input  wire logic          clk,                    // 100 MHz system clock
	input  wire logic          sys_rst,                // Synchronous reset, active high
	input  wire usbirq_addr_t  mem_addr,               // Data memory address
	input  wire logic          mem_rd,                 // Read strobe, one cycle
	input  wire logic          mem_wr,                 // Write strobe, one cycle
	input  wire usbirq_byte_t  mem_wdata,              // Write data
	output usbirq_byte_t       mem_rdata,              // Read data, registered
	output logic               mem_hit,                // Address matches one of the seven registers of this block
	input  wire logic [5:1]    out_ep_event,           // OUT endpoint events, pulses
	input  wire logic [5:0]    in_ep_flags,            // IN and control flags from elsewhere
	input  wire logic          frame_start_event,      // Start-of-frame token received
	input  wire usbirq_frame_t frame_number,           // Frame number with the token
	input  wire logic          bus_reset_event,        // Reset signalling detected
	input  wire logic          bus_resume_event,       // Resume signalling seen
	input  wire logic          bus_suspend_event,      // Suspend entered
	output usbirq_byte_t       in_mask,                // IN and control enables
	output logic               top_level_usb_irq_flag  // Combined interrupt request
);
	usbirq_byte_t  out_flags_r;      // OUT endpoint flags
	usbirq_byte_t  common_flags_r;   // Common bus flags
	usbirq_frame_t frame_r;          // Last received frame number
	usbirq_byte_t  rdata_r;          // Read data register
	usbirq_byte_t  rdata_nxt;        // Read data selection
	usbirq_byte_t  out_mask;         // OUT endpoint enables
	usbirq_byte_t  common_mask;      // Common enables
	usbirq_byte_t  out_set;          // Incoming OUT events placed at their bits
	usbirq_byte_t  common_set;       // Incoming common events placed at their bits
	logic          rd_out_flags;     // Read of the OUT flag register
	logic          rd_common_flags;  // Read of the common flag register
	logic          irq_r;            // Registered interrupt request

	assign rd_out_flags    = mem_rd && (mem_addr == `USBIRQ_OFS_OUT_FLAGS);
	assign rd_common_flags = mem_rd && (mem_addr == `USBIRQ_OFS_COMMON_FLAGS);
	assign out_set         = {2'b00, out_ep_event, 1'b0};
	assign common_set      = {4'h0, frame_start_event, bus_reset_event,
		bus_resume_event, bus_suspend_event};

	// Enable masks; reserved bits 7:6 stay writable as stored bits in the IN and OUT masks
	usbirq_mask_reg #(
		.RST_VAL (`USBIRQ_RST_IN_MASK),
		.WR_MASK (`USBIRQ_WMASK_IN)
	) u_in_mask (
		.clk     (clk),
		.sys_rst (sys_rst),
		.wr_en   (mem_wr && (mem_addr == `USBIRQ_OFS_IN_MASK)),
		.wr_data (mem_wdata),
		.value   (in_mask)
	);

	// Bit 0 is unused here and never stores a one
	usbirq_mask_reg #(
		.RST_VAL (`USBIRQ_RST_OUT_MASK),
		.WR_MASK (`USBIRQ_WMASK_OUT)
	) u_out_mask (
		.clk     (clk),
		.sys_rst (sys_rst),
		.wr_en   (mem_wr && (mem_addr == `USBIRQ_OFS_OUT_MASK)),
		.wr_data (mem_wdata),
		.value   (out_mask)
	);

	// Upper nibble reads zero
	usbirq_mask_reg #(
		.RST_VAL (`USBIRQ_RST_COMMON_MASK),
		.WR_MASK (`USBIRQ_WMASK_COMMON)
	) u_common_mask (
		.clk     (clk),
		.sys_rst (sys_rst),
		.wr_en   (mem_wr && (mem_addr == `USBIRQ_OFS_COMMON_MASK)),
		.wr_data (mem_wdata),
		.value   (common_mask)
	);

	// OUT flags: a new event in the read cycle survives the clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_flags_r <= 8'h00;
		end else if (rd_out_flags) begin
			out_flags_r <= out_set & `USBIRQ_OUT_EP_MASK;
		end else begin
			out_flags_r <= (out_flags_r | out_set) & `USBIRQ_OUT_EP_MASK;
		end
	end

	// Common flags set without regard to the enables
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			common_flags_r <= 8'h00;
		end else if (rd_common_flags) begin
			common_flags_r <= common_set & `USBIRQ_COMMON_EV_MASK;
		end else begin
			common_flags_r <= (common_flags_r | common_set) & `USBIRQ_COMMON_EV_MASK;
		end
	end

	// Frame number captured with each frame start
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frame_r <= `USBIRQ_RST_FRAME;
		end else if (frame_start_event) begin
			frame_r <= frame_number;
		end
	end

	// Read mux; unmapped offsets inside the block answer zero
	always_comb begin
		rdata_nxt = 8'h00;
		mem_hit   = 1'b1;
		unique case (mem_addr)
			`USBIRQ_OFS_OUT_FLAGS:    rdata_nxt = out_flags_r;
			`USBIRQ_OFS_COMMON_FLAGS: rdata_nxt = common_flags_r;
			`USBIRQ_OFS_IN_MASK:      rdata_nxt = in_mask;
			`USBIRQ_OFS_OUT_MASK:     rdata_nxt = out_mask;
			`USBIRQ_OFS_COMMON_MASK:  rdata_nxt = common_mask;
			`USBIRQ_OFS_FRAME_LOW:    rdata_nxt = frame_r[7:0];
			`USBIRQ_OFS_FRAME_HIGH:   rdata_nxt = {5'b00000, frame_r[10:8]};
			default:                  mem_hit   = 1'b0;
		endcase
	end

	// Read data held until the next read
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_r <= 8'h00;
		end else if (mem_rd) begin
			rdata_r <= rdata_nxt;
		end
	end

	// Interrupt: registered, so it follows the flags it reflects one edge later
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(out_flags_r & out_mask) | |(common_flags_r & common_mask)
				| |(in_ep_flags & in_mask[5:0]);
		end
	end

	assign mem_rdata              = rdata_r;
	assign top_level_usb_irq_flag = irq_r;
endmodule : usbirq_core

// ==== shared/usbirq_params.svh ====
// Register offsets, field positions, reset values and bit masks for the USB interrupt block
`ifndef USBIRQ_PARAMS_SVH
`define USBIRQ_PARAMS_SVH
`define USBIRQ_OFS_OUT_FLAGS    16'hde04
`define USBIRQ_OFS_COMMON_FLAGS 16'hde06
`define USBIRQ_OFS_IN_MASK      16'hde07
`define USBIRQ_OFS_OUT_MASK     16'hde09
`define USBIRQ_OFS_COMMON_MASK  16'hde0b
`define USBIRQ_OFS_FRAME_LOW    16'hde0c
`define USBIRQ_OFS_FRAME_HIGH   16'hde0d
`define USBIRQ_BIT_FRAME_START  3
`define USBIRQ_BIT_BUS_RESET    3'd2
`define USBIRQ_RST_IN_MASK      8'h3f
`define USBIRQ_RST_OUT_MASK     8'h3e
`define USBIRQ_RST_COMMON_MASK  8'h06
`define USBIRQ_RST_FRAME        11'h000
`define USBIRQ_WMASK_IN         8'hff
`define USBIRQ_WMASK_OUT        8'hfe
`define USBIRQ_WMASK_COMMON     8'h0f
`define USBIRQ_OUT_EP_MASK      8'h3e
`define USBIRQ_COMMON_EV_MASK   8'h0f
`endif

// ==== shared/usbirq_pkg.sv ====
// Types shared by the USB interrupt flag and mask block
package usbirq_pkg;
	typedef logic [7:0]  usbirq_byte_t;
	typedef logic [15:0] usbirq_addr_t;
	typedef logic [10:0] usbirq_frame_t;
endpackage : usbirq_pkg

// ==== hw/usbirq_mask_reg.sv ====
// One read/write mask register with reset value and writable-bit mask
`timescale 1ns/10ps
module usbirq_mask_reg
	import usbirq_pkg::*;
#(
	parameter usbirq_byte_t RST_VAL = 8'h00,
	parameter usbirq_byte_t WR_MASK = 8'hff
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         wr_en,
	input  wire usbirq_byte_t wr_data,
	output usbirq_byte_t      value
);
	usbirq_byte_t value_r;   // Stored enable bits

	// Unwritable bits stay at zero whatever software writes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			value_r <= RST_VAL;
		end else if (wr_en) begin
			value_r <= wr_data & WR_MASK;
		end
	end

	assign value = value_r;
endmodule : usbirq_mask_reg

// ==== test/usbirq_core_assertions.sv ====
// Checker for the USB interrupt flag and mask block
`timescale 1ns/10ps
module usbirq_core_chk
	import usbirq_pkg::*;
(
	input wire logic         clk,
	input wire logic         sys_rst,
	input wire usbirq_addr_t mem_addr,
	input wire logic         mem_rd,
	input wire logic         mem_wr,
	input wire usbirq_byte_t mem_rdata,
	input wire logic         mem_hit,
	input wire logic [5:0]   in_ep_flags,
	input wire logic         bus_reset_event,
	input wire logic         frame_start_event,
	input wire usbirq_byte_t in_mask,
	input wire logic         top_level_usb_irq_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Event, then a read of the common flags
	sequence s_rst_rd; bus_reset_event ##1 (mem_rd && mem_addr == 16'hde06); endsequence
	sequence s_sof_rd; frame_start_event ##1 (mem_rd && mem_addr == 16'hde06); endsequence
	a_reset_in_mask: assert property ($past(sys_rst) |-> in_mask == 8'h3f) else $error("in mask reset");
	a_out_rsvd: assert property (mem_rd && mem_addr == 16'hde04 |=> mem_rdata[7:6] == 2'h0 && !mem_rdata[0]) else $error("out rsvd");
	a_common_rsvd: assert property (mem_rd && mem_addr == 16'hde06 |=> mem_rdata[7:4] == 4'h0) else $error("common rsvd");
	a_rst_flag_read: assert property (s_rst_rd |=> mem_rdata[2]) else $error("reset flag");
	a_sof_flag_read: assert property (s_sof_rd |=> mem_rdata[3]) else $error("frame flag");
	a_rdata_hold: assert property (!mem_rd |=> $stable(mem_rdata)) else $error("rdata moved");
	a_mask_hold: assert property (!mem_wr |=> $stable(in_mask)) else $error("in mask moved");
	a_high_hit: assert property (mem_addr == 16'hde0d |-> mem_hit) else $error("high miss");
	a_ctrl_irq: assert property (in_mask[0] && in_ep_flags[0] |-> ##[1:2] top_level_usb_irq_flag) else $error("no irq");
endmodule : usbirq_core_chk
bind usbirq_core usbirq_core_chk i_chk (.clk(clk), .sys_rst(sys_rst), .mem_addr(mem_addr),
	.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata), .mem_hit(mem_hit),
	.in_ep_flags(in_ep_flags), .bus_reset_event(bus_reset_event),
	.frame_start_event(frame_start_event), .in_mask(in_mask),
	.top_level_usb_irq_flag(top_level_usb_irq_flag));

// ==== test/test_usbirq_core.sv ====
// Self-checking bench for the USB interrupt flag and mask block
`timescale 1ns/10ps
module test_usbirq_core;
	import usbirq_pkg::*;
	logic          clk = 1'b0;
	logic          sys_rst = 1'b1;
	usbirq_addr_t  mem_addr = 16'h0000;
	logic          mem_rd = 1'b0;
	logic          mem_wr = 1'b0;
	usbirq_byte_t  mem_wdata = 8'h00;
	usbirq_byte_t  mem_rdata;
	logic          mem_hit;
	logic [5:1]    out_ep = 5'h00;
	logic [5:0]    in_flags = 6'h00;
	logic [3:0]    bus_ev = 4'h0;   // Frame start, reset, resume, suspend
	usbirq_frame_t frame = 11'h000;
	usbirq_byte_t  in_mask;
	logic          irq;
	int            err_total = 0;
	int            check_count = 0;
	int            cycles = 0;
	always #5 clk = ~clk;
	usbirq_core i_usbirq_core (.clk(clk), .sys_rst(sys_rst), .mem_addr(mem_addr),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_hit(mem_hit), .out_ep_event(out_ep), .in_ep_flags(in_flags),
		.frame_start_event(bus_ev[3]), .frame_number(frame), .bus_reset_event(bus_ev[2]),
		.bus_resume_event(bus_ev[1]), .bus_suspend_event(bus_ev[0]), .in_mask(in_mask),
		.top_level_usb_irq_flag(irq));
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	task automatic chk(input usbirq_byte_t got, input usbirq_byte_t exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One strobe cycle; strobes drop after the sampling edge
	task automatic acc(input usbirq_addr_t a, input logic w, input usbirq_byte_t d);
		@(posedge clk) #1;
		mem_addr = a;
		mem_wr = w;
		mem_rd = !w;
		mem_wdata = d;
		@(posedge clk) #1;
		mem_wr = 1'b0;
		mem_rd = 1'b0;
	endtask : acc
	task automatic rd(input usbirq_addr_t a, input usbirq_byte_t exp);
		acc(a, 1'b0, 8'h00);
		chk(mem_rdata, exp);
	endtask : rd
	// One-cycle event pulses, then one cycle for the request to land
	task automatic ev(input logic [5:1] o, input logic [3:0] b);
		@(posedge clk) #1;
		out_ep = o;
		bus_ev = b;
		@(posedge clk) #1;
		out_ep = 5'h00;
		bus_ev = 4'h0;
		@(posedge clk) #1;
	endtask : ev
	// Hang guard, far above the 54 or so cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			report_and_stop();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		#1 sys_rst = 1'b0;
		rd(16'hde07, 8'h3f);
		rd(16'hde09, 8'h3e);
		rd(16'hde0b, 8'h06);
		rd(16'hde0c, 8'h00);
		$display("reset test done");
		acc(16'hde09, 1'b1, 8'h00);
		acc(16'hde0b, 1'b1, 8'h00);
		frame = 11'h5a7;
		ev(5'h1f, 4'hf);
		chk({7'h00, irq}, 8'h00);
		rd(16'hde04, 8'h3e);
		rd(16'hde04, 8'h00);
		rd(16'hde06, 8'h0f);
		rd(16'hde06, 8'h00);
		rd(16'hde0d, 8'h05);
		acc(16'hde0c, 1'b1, 8'h00);
		rd(16'hde0c, 8'ha7);
		rd(16'hde05, 8'h00);
		$display("flag test done");
		acc(16'hde0b, 1'b1, 8'hff);
		rd(16'hde0b, 8'h0f);
		ev(5'h00, 4'h1);
		chk({7'h00, irq}, 8'h01);
		rd(16'hde06, 8'h01);
		// The request follows the cleared flag one edge later
		@(posedge clk) #1;
		chk({7'h00, irq}, 8'h00);
		acc(16'hde09, 1'b1, 8'h3f);
		rd(16'hde09, 8'h3e);
		in_flags = 6'h01;
		@(posedge clk) #1;
		@(posedge clk) #1;
		chk({7'h00, irq}, 8'h01);
		acc(16'hde07, 1'b1, 8'h2a);
		chk(in_mask, 8'h2a);
		@(posedge clk) #1;
		chk({7'h00, irq}, 8'h00);
		in_flags = 6'h00;
		$display("mask test done");
		report_and_stop();
	end
endmodule : test_usbirq_core
